// ===== hdl/uvp_ctrl.sv
// Programmer-side controller driving a 16K x 8 UV-erasable memory by its pins.
// Assumes pin inputs are synchronous to clk_i and external drivers switch supplies.
`default_nettype none
module uvp_ctrl #(
  parameter int unsigned NUM_DEV    = 1,
  parameter int unsigned PULSE_CYC  = uvp_pkg::PULSE_CYC,
  parameter int unsigned MAX_PULSES = uvp_pkg::MAX_PULSES,
  parameter int unsigned DEV_W      = (NUM_DEV > 1) ? $clog2(NUM_DEV) : 1
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        clk_en_i,
  // Command port
  input  wire logic                        cmd_valid_i,
  input  wire logic [1:0]                  cmd_op_i,
  input  wire logic [DEV_W-1:0]            cmd_dev_i,
  input  wire logic [uvp_pkg::ADDR_W-1:0]  cmd_addr_i,
  input  wire logic [uvp_pkg::DATA_W-1:0]  cmd_data_i,
  output logic                             cmd_ready_o,
  // Answer port
  output logic                             rsp_valid_o,
  output logic [1:0]                       rsp_status_o,
  output logic [uvp_pkg::DATA_W-1:0]       rsp_data_o,
  output logic [uvp_pkg::DATA_W-1:0]       rsp_id_o,
  output logic [7:0]                       rsp_pulses_o,
  // Memory pins
  output logic [uvp_pkg::ADDR_W-1:0]       mem_addr_o,
  output logic                             mem_id_trigger_hv_o,
  output logic [NUM_DEV-1:0]               mem_chip_sel_n_o,
  output logic                             mem_out_drive_n_o,
  output logic                             mem_program_pulse_n_o,
  output logic                             mem_prog_supply_hv_o,
  input  wire logic [uvp_pkg::DATA_W-1:0]  mem_data_i,
  output logic [uvp_pkg::DATA_W-1:0]       mem_data_o,
  output logic                             mem_data_oe_n_o
);
  localparam int unsigned TW = 12;
  localparam logic [TW-1:0] PULSE_LD  = TW'(PULSE_CYC - 1);
  localparam logic [TW-1:0] SETTLE_LD = TW'(uvp_pkg::SETTLE_CYC - 1);

  initial
  begin
    if (NUM_DEV < 1 || NUM_DEV > 16) $error("uvp_ctrl: NUM_DEV out of range");
    if (PULSE_CYC < 2 || PULSE_CYC > 4095) $error("uvp_ctrl: PULSE_CYC out of range");
    if (MAX_PULSES < 1 || MAX_PULSES > 255) $error("uvp_ctrl: MAX_PULSES out of range");
  end

  typedef struct packed {
    uvp_pkg::uvp_state_t         st;
    logic [1:0]                  op;
    logic [DEV_W-1:0]            dev;
    logic [uvp_pkg::ADDR_W-1:0]  addr;
    logic [uvp_pkg::DATA_W-1:0]  data;
    logic [7:0]                  pulses;
    logic [uvp_pkg::DATA_W-1:0]  maker;
    logic                        rdy;
    logic                        rvalid;
    logic [1:0]                  rstat;
    logic [uvp_pkg::DATA_W-1:0]  rdata;
    logic [uvp_pkg::DATA_W-1:0]  rid;
    logic [7:0]                  rpulses;
    logic [uvp_pkg::ADDR_W-1:0]  pa;
    logic                        hv;
    logic [NUM_DEV-1:0]          cs_n;
    logic                        oe_n;
    logic                        pgm_n;
    logic                        vpp;
    logic [uvp_pkg::DATA_W-1:0]  dout;
    logic                        doe_n;
  } uvp_ctrl_state_t;

  uvp_ctrl_state_t s_q;
  uvp_ctrl_state_t s_d;
  logic            t_load;
  logic [TW-1:0]   t_count;
  logic            t_done;

  // One-hot chip-select decode, active low, so only one device ever responds
  function automatic logic [NUM_DEV-1:0] sel_n(input logic [DEV_W-1:0] d);
    logic [NUM_DEV-1:0] v;
    v = '1;
    for (int i = 0; i < NUM_DEV; i++)
      if (d == DEV_W'(i))
        v[i] = 1'b0;
    return v;
  endfunction : sel_n

  // Odd parity holds when the XOR over the byte is one
  function automatic logic odd_par(input logic [uvp_pkg::DATA_W-1:0] b);
    return ^b;
  endfunction : odd_par

  uvp_timer #(
    .WIDTH     (TW)
  ) u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .load_i    (t_load),
    .count_i   (t_count),
    .expired_o (t_done)
  );

  // Sequencer: every pin level is a register, so changes are glitch free
  always_comb
  begin
    s_d     = s_q;
    t_load  = 1'b0;
    t_count = SETTLE_LD;
    s_d.rvalid = 1'b0;
    case (s_q.st)
      uvp_pkg::UVP_IDLE:
      begin
        s_d.rdy = 1'b1;
        if (cmd_valid_i && s_q.rdy)
        begin
          s_d.rdy    = 1'b0;
          s_d.op     = cmd_op_i;
          s_d.dev    = cmd_dev_i;
          s_d.addr   = cmd_addr_i;
          s_d.pa     = cmd_addr_i;
          s_d.data   = cmd_data_i;
          s_d.pulses = '0;
          s_d.cs_n   = sel_n(cmd_dev_i);
          t_load     = 1'b1;
          case (cmd_op_i)
            uvp_pkg::CMD_PROGRAM:
            begin
              s_d.vpp   = 1'b1;
              s_d.cs_n  = '1;
              s_d.dout  = cmd_data_i;
              s_d.doe_n = 1'b0;
              s_d.st    = uvp_pkg::UVP_SETUP;
            end
            uvp_pkg::CMD_IDENT:
            begin
              s_d.pa    = '0;
              s_d.hv    = 1'b1;
              s_d.oe_n  = 1'b0;
              s_d.st    = uvp_pkg::UVP_ID0;
            end
            uvp_pkg::CMD_VERIFY:
            begin
              s_d.pa    = '0;
              s_d.oe_n  = 1'b0;
              s_d.st    = uvp_pkg::UVP_SWEEP;
            end
            default:
            begin
              s_d.oe_n  = 1'b0;
              s_d.st    = uvp_pkg::UVP_READ;
            end
          endcase
        end
      end
      uvp_pkg::UVP_SETUP:
      begin
        if (t_done)
        begin
          s_d.cs_n  = sel_n(s_q.dev);
          s_d.pgm_n = 1'b0;
          s_d.pulses = s_q.pulses + 8'h01;
          t_load    = 1'b1;
          t_count   = PULSE_LD;
          s_d.st    = uvp_pkg::UVP_PULSE;
        end
      end
      uvp_pkg::UVP_PULSE:
      begin
        if (t_done)
        begin
          s_d.pgm_n = 1'b1;
          s_d.doe_n = 1'b1;                                     // Release bus before device drives
          t_load    = 1'b1;
          s_d.st    = uvp_pkg::UVP_RECOVER;
        end
      end
      uvp_pkg::UVP_RECOVER:
      begin
        if (t_done)
        begin
          s_d.oe_n = 1'b0;
          t_load   = 1'b1;
          s_d.st   = uvp_pkg::UVP_VREAD;
        end
      end
      uvp_pkg::UVP_VREAD:
      begin
        if (t_done)
        begin
          s_d.oe_n  = 1'b1;
          s_d.rdata = mem_data_i;
          s_d.rpulses = s_q.pulses;
          t_load    = 1'b1;
          if (mem_data_i == s_q.data)
          begin
            s_d.rstat = uvp_pkg::ST_OK;
            s_d.st    = uvp_pkg::UVP_DONE;
          end
          else if (s_q.pulses >= 8'(MAX_PULSES))
          begin
            s_d.rstat = uvp_pkg::ST_FAIL;
            s_d.st    = uvp_pkg::UVP_DONE;
          end
          else
          begin
            s_d.cs_n  = '1;
            s_d.dout  = s_q.data;
            s_d.doe_n = 1'b0;
            s_d.st    = uvp_pkg::UVP_SETUP;
          end
        end
      end
      uvp_pkg::UVP_READ:
      begin
        if (t_done)
        begin
          s_d.rdata = mem_data_i;
          s_d.rstat = uvp_pkg::ST_OK;
          s_d.rpulses = '0;
          t_load    = 1'b1;
          s_d.st    = uvp_pkg::UVP_DONE;
        end
      end
      uvp_pkg::UVP_ID0:
      begin
        if (t_done)
        begin
          s_d.maker = mem_data_i;
          s_d.pa[uvp_pkg::ID_SEL_BIT] = 1'b1;
          t_load    = 1'b1;
          s_d.st    = uvp_pkg::UVP_ID1;
        end
      end
      uvp_pkg::UVP_ID1:
      begin
        if (t_done)
        begin
          s_d.rdata = s_q.maker;
          s_d.rid   = mem_data_i;
          s_d.rpulses = '0;
          s_d.rstat = (odd_par(s_q.maker) && odd_par(mem_data_i)) ? uvp_pkg::ST_OK
                                                                   : uvp_pkg::ST_BADPAR;
          t_load    = 1'b1;
          s_d.st    = uvp_pkg::UVP_DONE;
        end
      end
      uvp_pkg::UVP_SWEEP:
      begin
        if (t_done)
        begin
          t_load = 1'b1;
          // Verify mode compares each byte to erased when op data is erased value
          if ((s_q.data == uvp_pkg::ERASED_BYTE) && (mem_data_i != uvp_pkg::ERASED_BYTE))
          begin
            s_d.rstat = uvp_pkg::ST_NOT_ERASED;
            s_d.rdata = mem_data_i;
            s_d.rid   = s_q.pa[7:0];
            s_d.st    = uvp_pkg::UVP_DONE;
          end
          else if (s_q.pa == '1)
          begin
            s_d.rstat = uvp_pkg::ST_OK;
            s_d.rdata = mem_data_i;
            s_d.st    = uvp_pkg::UVP_DONE;
          end
          else
            s_d.pa = s_q.pa + 1'b1;
          s_d.rpulses = '0;
        end
      end
      uvp_pkg::UVP_DONE:
      begin
        if (t_done)
        begin
          s_d.cs_n  = '1;
          s_d.oe_n  = 1'b1;
          s_d.vpp   = 1'b0;
          s_d.hv    = 1'b0;
          s_d.doe_n = 1'b1;
          s_d.rvalid = 1'b1;
          s_d.st    = uvp_pkg::UVP_IDLE;
        end
      end
      default:
        s_d.st = uvp_pkg::UVP_IDLE;
    endcase
  end

  // State register; clock enable freezes every field
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q       <= '0;
      s_q.st    <= uvp_pkg::UVP_IDLE;
      s_q.cs_n  <= '1;
      s_q.oe_n  <= 1'b1;
      s_q.pgm_n <= 1'b1;
      s_q.doe_n <= 1'b1;
    end
    else if (clk_en_i)
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign cmd_ready_o           = s_q.rdy;
  assign rsp_valid_o           = s_q.rvalid;
  assign rsp_status_o          = s_q.rstat;
  assign rsp_data_o            = s_q.rdata;
  assign rsp_id_o              = s_q.rid;
  assign rsp_pulses_o          = s_q.rpulses;
  assign mem_addr_o            = s_q.pa;
  assign mem_id_trigger_hv_o   = s_q.hv;
  assign mem_chip_sel_n_o      = s_q.cs_n;
  assign mem_out_drive_n_o     = s_q.oe_n;
  assign mem_program_pulse_n_o = s_q.pgm_n;
  assign mem_prog_supply_hv_o  = s_q.vpp;
  assign mem_data_o            = s_q.dout;
  assign mem_data_oe_n_o       = s_q.doe_n;
endmodule : uvp_ctrl
`default_nettype wire

// ===== common/uvp_pkg.sv
// Package for the programmer controller of a 16K x 8 UV-erasable memory.
// Assumes a 25 MHz system clock; pins reach the memory through level shifters.
`default_nettype none
package uvp_pkg;
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned PULSE_US      = 100;
  localparam int unsigned PULSE_CYC     = (PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SETTLE_NS     = 200;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MAX_PULSES    = 25;
  localparam int unsigned ID_TRIG_BIT   = 9;
  localparam int unsigned ID_SEL_BIT    = 0;
  localparam int unsigned PARITY_BIT    = 7;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [1:0]  CMD_READ      = 2'h0;
  localparam logic [1:0]  CMD_PROGRAM   = 2'h1;
  localparam logic [1:0]  CMD_IDENT     = 2'h2;
  localparam logic [1:0]  CMD_VERIFY    = 2'h3;
  localparam logic [1:0]  ST_OK         = 2'h0;
  localparam logic [1:0]  ST_FAIL       = 2'h1;
  localparam logic [1:0]  ST_BADPAR     = 2'h2;
  localparam logic [1:0]  ST_NOT_ERASED = 2'h3;

  typedef enum logic [3:0] {
    UVP_IDLE    = 4'h0,
    UVP_SETUP   = 4'h1,
    UVP_PULSE   = 4'h2,
    UVP_RECOVER = 4'h3,
    UVP_VREAD   = 4'h4,
    UVP_READ    = 4'h5,
    UVP_ID0     = 4'h6,
    UVP_ID1     = 4'h7,
    UVP_SWEEP   = 4'h8,
    UVP_DONE    = 4'h9
  } uvp_state_t;
endpackage : uvp_pkg
`default_nettype wire

// ===== hdl/uvp_timer.sv
// Down-counter for pin hold times of the programming controller.
// Assumes a load strobe and a clock enable from the owning sequencer.
`default_nettype none
module uvp_timer #(
  parameter int unsigned WIDTH = 12
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clk_en_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  // Status
  output logic                  expired_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } uvp_timer_state_t;

  uvp_timer_state_t s_q;
  uvp_timer_state_t s_d;

  initial
  begin
    if (WIDTH < 2) $error("uvp_timer: WIDTH too small");
  end

  // Load wins over counting so back-to-back phases never merge
  always_comb
  begin
    s_d = s_q;
    if (load_i)
      s_d.cnt = count_i;
    else if (s_q.cnt != '0)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_q <= '0;
    else if (clk_en_i)
      s_q <= s_d;
  end

  // Expiry ignores load, so the owner's load decision cannot feed back into it
  assign expired_o = (s_q.cnt == '0);
endmodule : uvp_timer
`default_nettype wire

// ===== verif/uvp_ctrl_assertions.sv
// Checker on the pins and answers of the programming controller.
// Assumes it is bound to uvp_ctrl and sees only that module's ports.
`default_nettype none
module uvp_ctrl_assertions #(
  parameter int unsigned NUM_DEV    = 1,
  parameter int unsigned PULSE_CYC  = 8,
  parameter int unsigned MAX_PULSES = 3,
  parameter int unsigned DEV_W      = 1
) (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                reset_n_i,
  input wire logic                clk_en_i,
  // Answers
  input wire logic                rsp_valid_o,
  input wire logic [1:0]          rsp_status_o,
  input wire logic [7:0]          rsp_pulses_o,
  // Memory pins
  input wire logic [13:0]         mem_addr_o,
  input wire logic                mem_id_trigger_hv_o,
  input wire logic [NUM_DEV-1:0]  mem_chip_sel_n_o,
  input wire logic                mem_out_drive_n_o,
  input wire logic                mem_program_pulse_n_o,
  input wire logic                mem_prog_supply_hv_o,
  input wire logic                mem_data_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_cnt_q;
  logic [15:0] low_cnt_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Width of the current program pulse, frozen with the clock enable
  always_comb
  begin
    low_cnt_d = low_cnt_q;
    if (clk_en_i)
      low_cnt_d = mem_program_pulse_n_o ? 16'h0000 : low_cnt_q + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      low_cnt_q <= 16'h0000;
    else
      low_cnt_q <= low_cnt_d;
  end

  prog_needs_vpp_a: assert property (!mem_program_pulse_n_o |-> mem_prog_supply_hv_o)
    else $error("program pulse without programming supply");
  pulse_width_a: assert property ($rose(mem_program_pulse_n_o) |-> low_cnt_q == 16'(PULSE_CYC))
    else $error("program pulse width wrong");
  byte_driven_a: assert property (!mem_program_pulse_n_o |-> !mem_data_oe_n_o)
    else $error("data not driven during pulse");
  no_contention_a: assert property (!mem_data_oe_n_o |-> mem_out_drive_n_o)
    else $error("output drive while controller drives data");
  one_select_a: assert property ($onehot0(~mem_chip_sel_n_o))
    else $error("more than one device selected");
  verify_pins_a: assert property (!mem_out_drive_n_o && mem_prog_supply_hv_o |-> mem_program_pulse_n_o)
    else $error("verify read with pulse line low");
  id_addr_low_a: assert property (mem_id_trigger_hv_o |-> (mem_addr_o & 14'h3FFE) == 14'h0000)
    else $error("address lines not low in identification");
  fail_count_a: assert property (rsp_valid_o && rsp_status_o == 2'h1 |-> rsp_pulses_o == 8'(MAX_PULSES))
    else $error("failed program without full pulse count");
  read_selects_a: assert property (!mem_out_drive_n_o |-> !(&mem_chip_sel_n_o))
    else $error("output drive with no device selected");

  cover property (rsp_valid_o && rsp_status_o == 2'h1);
  cover property (rsp_valid_o && mem_id_trigger_hv_o == 1'b0 && rsp_status_o == 2'h2);
  cover property ($rose(mem_program_pulse_n_o));
endmodule : uvp_ctrl_assertions

bind uvp_ctrl uvp_ctrl_assertions #(.NUM_DEV(NUM_DEV), .PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES),
  .DEV_W(DEV_W)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .rsp_valid_o(rsp_valid_o),
  .rsp_status_o(rsp_status_o), .rsp_pulses_o(rsp_pulses_o), .mem_addr_o(mem_addr_o),
  .mem_id_trigger_hv_o(mem_id_trigger_hv_o), .mem_chip_sel_n_o(mem_chip_sel_n_o),
  .mem_out_drive_n_o(mem_out_drive_n_o), .mem_program_pulse_n_o(mem_program_pulse_n_o),
  .mem_prog_supply_hv_o(mem_prog_supply_hv_o), .mem_data_oe_n_o(mem_data_oe_n_o));
`default_nettype wire

// ===== verif/uvp_mem_model.sv
// Behavioural model of one 16K x 8 UV-erasable memory, pin level only.
// Assumes the bench resolves the shared data lines from all drivers.
`default_nettype none
module uvp_mem_model #(
  parameter logic [7:0] MAKER_ID = 8'h2A, // Arbitrary value, odd parity
  parameter logic [7:0] DEV_ID   = 8'h8C  // Arbitrary value, odd parity
) (
  // Pins
  input  wire logic [13:0] addr_i,
  input  wire logic        id_hv_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        pulse_n_i,
  input  wire logic        vpp_i,
  input  wire logic [7:0]  data_i,
  // Fault and ageing controls from the bench
  input  wire logic [7:0]  need_i,
  input  wire logic        bad_id_i,
  output logic [7:0]       data_o,
  output logic             drive_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:16383];
  logic [7:0] cnt;
  wire        prog = vpp_i && !cs_n_i && !pulse_n_i;

  // Erased state is all ones
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    cnt = 8'h00;
  end

  // A slow cell needs several pulses before its zeros stick
  always @(addr_i) cnt = 8'h00;
  always @(posedge prog)
  begin
    cnt = cnt + 8'h01;
    if (cnt >= need_i) mem[addr_i] = mem[addr_i] & data_i;
  end

  // Outputs only with both selects low and the pulse line high
  assign drive_o = !cs_n_i && !oe_n_i && pulse_n_i;
  assign data_o  = !id_hv_i ? mem[addr_i] : addr_i[0] ? (DEV_ID ^ {7'h00, bad_id_i}) : MAKER_ID;
endmodule : uvp_mem_model
`default_nettype wire

// ===== verif/uvp_ctrl_tb.sv
// Self-checking bench for uvp_ctrl with two memory models.
// Assumes short pulse and pulse-limit parameters to keep the run brief.
`default_nettype none
`define CHK(a, b) total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end
module uvp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, bad_id = 0, clk_en = 1;
  logic [1:0]  cmd_op_i = 2'h0, rsp_status_o, mem_chip_sel_n_o;
  logic [0:0]  cmd_dev_i = 1'b0;
  logic [13:0] cmd_addr_i = 14'h0000, mem_addr_o;
  logic [7:0]  cmd_data_i = 8'h00, need0 = 8'h01, need1 = 8'h01, bus, dout0, dout1;
  logic [7:0]  rsp_data_o, rsp_id_o, rsp_pulses_o, mem_data_o;
  logic        cmd_ready_o, rsp_valid_o, mem_id_trigger_hv_o, mem_out_drive_n_o, mem_program_pulse_n_o;
  logic        mem_prog_supply_hv_o, mem_data_oe_n_o, drv0, drv1;
  int          num_errors = 0, total_checks = 0, cyc = 0;

  always #20 clk_i = ~clk_i;

  uvp_ctrl #(.NUM_DEV(2), .PULSE_CYC(8), .MAX_PULSES(3)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_dev_i(cmd_dev_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_status_o(rsp_status_o), .rsp_data_o(rsp_data_o), .rsp_id_o(rsp_id_o), .rsp_pulses_o(rsp_pulses_o),
    .mem_addr_o(mem_addr_o), .mem_id_trigger_hv_o(mem_id_trigger_hv_o), .mem_chip_sel_n_o(mem_chip_sel_n_o),
    .mem_out_drive_n_o(mem_out_drive_n_o), .mem_program_pulse_n_o(mem_program_pulse_n_o),
    .mem_prog_supply_hv_o(mem_prog_supply_hv_o), .mem_data_i(bus), .mem_data_o(mem_data_o),
    .mem_data_oe_n_o(mem_data_oe_n_o));

  // Two devices share every pin except chip-select
  uvp_mem_model i_dev0 (.addr_i(mem_addr_o), .id_hv_i(mem_id_trigger_hv_o), .cs_n_i(mem_chip_sel_n_o[0]),
    .oe_n_i(mem_out_drive_n_o), .pulse_n_i(mem_program_pulse_n_o), .vpp_i(mem_prog_supply_hv_o), .data_i(bus),
    .need_i(need0), .bad_id_i(bad_id), .data_o(dout0), .drive_o(drv0));
  uvp_mem_model i_dev1 (.addr_i(mem_addr_o), .id_hv_i(mem_id_trigger_hv_o), .cs_n_i(mem_chip_sel_n_o[1]),
    .oe_n_i(mem_out_drive_n_o), .pulse_n_i(mem_program_pulse_n_o), .vpp_i(mem_prog_supply_hv_o), .data_i(bus),
    .need_i(need1), .bad_id_i(bad_id), .data_o(dout1), .drive_o(drv1));

  // A floating bus shows a changing pattern, never the last byte
  always_comb
    bus = !mem_data_oe_n_o ? mem_data_o : drv0 ? dout0 : drv1 ? dout1 : ~cyc[7:0];

  // Cut a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Hold the request until taken, then wait for the answer pulse
  task automatic do_cmd(input logic [1:0] op, input logic dev, input logic [13:0] addr, input logic [7:0] data);
    int n;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_op_i    = op;
    cmd_dev_i   = dev;
    cmd_addr_i  = addr;
    cmd_data_i  = data;
    n = 0;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 100);
    #1;
    cmd_valid_i = 1'b0;
    n = 0;
    do @(posedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 5000);
    `CHK(rsp_valid_o, 1'b1)
  endtask : do_cmd

  task automatic t_reset();
    `CHK(mem_chip_sel_n_o, 2'b11)
    `CHK(mem_prog_supply_hv_o, 1'b0)
  endtask : t_reset

  task automatic t_read_blank();
    do_cmd(uvp_pkg::CMD_READ, 1'b0, 14'h3FFF, 8'h00);
    `CHK(rsp_data_o, uvp_pkg::ERASED_BYTE)
  endtask : t_read_blank

  // Two pulses needed; the other device must stay blank
  task automatic t_program();
    need0 = 8'h02;
    do_cmd(uvp_pkg::CMD_PROGRAM, 1'b0, 14'h0123, 8'hA5);
    `CHK(rsp_status_o, uvp_pkg::ST_OK)
    `CHK(rsp_pulses_o, 8'h02)
    do_cmd(uvp_pkg::CMD_READ, 1'b0, 14'h0123, 8'h00);
    `CHK(rsp_data_o, 8'hA5)
    do_cmd(uvp_pkg::CMD_READ, 1'b1, 14'h0123, 8'h00);
    `CHK(rsp_data_o, 8'hFF)
  endtask : t_program

  // A cell that never takes within the pulse limit; a stall mid-pulse must not shorten the pulse
  task automatic t_prog_fail();
    need1 = 8'h05;
    fork
      do_cmd(uvp_pkg::CMD_PROGRAM, 1'b1, 14'h0200, 8'h00);
      begin
        repeat (12) @(posedge clk_i);
        #1;
        clk_en = 1'b0;
        repeat (7) @(posedge clk_i);
        #1;
        `CHK(mem_program_pulse_n_o, 1'b0)
        clk_en = 1'b1;
      end
    join
    `CHK(rsp_status_o, uvp_pkg::ST_FAIL)
    `CHK(rsp_pulses_o, 8'h03)
  endtask : t_prog_fail

  task automatic t_ident();
    do_cmd(uvp_pkg::CMD_IDENT, 1'b0, 14'h0000, 8'h00);
    `CHK(rsp_data_o, 8'h2A)
    `CHK(rsp_id_o, 8'h8C)
    `CHK(rsp_status_o, uvp_pkg::ST_OK)
    bad_id = 1'b1;
    do_cmd(uvp_pkg::CMD_IDENT, 1'b1, 14'h0000, 8'h00);
    `CHK(rsp_status_o, uvp_pkg::ST_BADPAR)
    bad_id = 1'b0;
  endtask : t_ident

  // Blank sweep stops at the programmed byte
  task automatic t_sweep();
    do_cmd(uvp_pkg::CMD_VERIFY, 1'b0, 14'h0000, 8'hFF);
    `CHK(rsp_status_o, uvp_pkg::ST_NOT_ERASED)
    `CHK(rsp_data_o, 8'hA5)
    `CHK(rsp_id_o, 8'h23)
  endtask : t_sweep

  initial
  begin
    repeat (3) @(posedge clk_i);
    #1;
    t_reset();
    reset_n_i = 1'b1;
    t_read_blank();
    t_program();
    t_prog_fail();
    t_ident();
    t_sweep();
    stop_test();
  end
endmodule : uvp_ctrl_tb
`undef CHK
`default_nettype wire
